// ### verilog/dcc_top.sv
`timescale 1ns/10ps
module dcc_top
  import dcc_pkg::*;
#(
  parameter int SYNC_STAGES = DCC_SYNC_STAGES
) (
  input  wire logic             REF_CLK_I,
  input  wire logic             RSTN_I,
  input  wire dcc_sfr_req_type  SFR_REQ_I,
  output logic [7:0]            SFR_RDATA_O,
  input  wire logic             CMP_A_RAW_I,
  input  wire logic             CMP_B_RAW_I,
  input  wire logic             CMP_A_RST_SEL_I,
  output dcc_core_cfg_type      CMP_A_CFG_O,
  output dcc_core_cfg_type      CMP_B_CFG_O,
  output logic                  CMP_A_PIN_O,
  output logic                  CMP_B_PIN_O,
  output logic                  CMP_A_IRQ_O,
  output logic                  CMP_B_IRQ_O,
  output logic                  CMP_A_RST_REQ_O
);

  //////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  // Read images and struct fields assume this byte layout
  if (DCC_CTRL_ON_BIT != 7 || DCC_CTRL_RES_BIT != 6 ||
      DCC_CTRL_RISE_BIT != 5 || DCC_CTRL_FALL_BIT != 4 ||
      DCC_CTRL_PHYST_LSB != 2 || DCC_CTRL_NHYST_LSB != 0) begin : g_bad_ctrl
    $error("Control field positions differ from the read image");
  end
  if (DCC_MODE_RISE_ON_BIT != 5 || DCC_MODE_FALL_ON_BIT != 4 ||
      DCC_MODE_SPEED_LSB != 0) begin : g_bad_mode
    $error("Mode field positions differ from the read image");
  end

  // Both comparators share offsets, so their pages must differ
  if (DCC_PAGE_A == DCC_PAGE_B) begin : g_bad_pages
    $error("Comparator pages must differ");
  end

  //////////////////////////////////////////////////////////////////////////
  // Functions

  // Decode which comparator a page selects, zero when none
  function automatic logic [1:0] page_hit(input logic [7:0] page);
    page_hit = 2'b00;
    if (page == DCC_PAGE_A) begin
      page_hit = 2'b01;
    end else if (page == DCC_PAGE_B) begin
      page_hit = 2'b10;
    end
  endfunction

  // Build the control register read image
  function automatic logic [7:0] ctrl_image(
    input logic       on,
    input logic       res,
    input logic       rise,
    input logic       fall,
    input logic [1:0] ph,
    input logic [1:0] nh
  );
    ctrl_image = {on, res, rise, fall, ph, nh};
  endfunction

  // Build the mode register read image, unused bits as zero
  function automatic logic [7:0] mode_image(
    input logic       rise_on,
    input logic       fall_on,
    input logic [1:0] speed
  );
    mode_image = {2'b00, rise_on, fall_on, 2'b00, speed};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Declarations: index 0 is comparator A, index 1 is comparator B

  logic [SYNC_STAGES-1:0] sync_a_q;
  logic [SYNC_STAGES-1:0] sync_a_d;
  logic [SYNC_STAGES-1:0] sync_b_q;
  logic [SYNC_STAGES-1:0] sync_b_d;
  logic [1:0]             prev_q;
  logic [1:0]             prev_d;
  logic [1:0]             res_now;
  logic [1:0]             rise_evt;
  logic [1:0]             fall_evt;

  logic [1:0]             on_q;
  logic [1:0]             on_d;
  logic [1:0]             rise_flag_q;
  logic [1:0]             rise_flag_d;
  logic [1:0]             fall_flag_q;
  logic [1:0]             fall_flag_d;
  logic [1:0]             pos_hyst_q [2];
  logic [1:0]             pos_hyst_d [2];
  logic [1:0]             neg_hyst_q [2];
  logic [1:0]             neg_hyst_d [2];
  logic [1:0]             rise_irq_on_q;
  logic [1:0]             rise_irq_on_d;
  logic [1:0]             fall_irq_on_q;
  logic [1:0]             fall_irq_on_d;
  logic [1:0]             speed_sel_q [2];
  logic [1:0]             speed_sel_d [2];

  logic [1:0]             sel;
  logic                   hit_ctrl;
  logic                   hit_mode;
  logic [1:0]             wr_ctrl;
  logic [1:0]             wr_mode;

  logic [7:0]             rdata_q;
  logic [7:0]             rdata_d;
  logic [1:0]             pin_q;
  logic [1:0]             pin_d;
  logic [1:0]             irq_q;
  logic [1:0]             irq_d;
  logic                   rst_req_q;
  logic                   rst_req_d;

  //////////////////////////////////////////////////////////////////////////
  // Synchronisers

  // Shift raw results in; only the last stage is read downstream
  always_comb begin
    sync_a_d = {sync_a_q[SYNC_STAGES-2:0], CMP_A_RAW_I};
    sync_b_d = {sync_b_q[SYNC_STAGES-2:0], CMP_B_RAW_I};
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sync_a_q <= '0;
      sync_b_q <= '0;
    end else begin
      sync_a_q <= sync_a_d;
      sync_b_q <= sync_b_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Edge detection

  // Edges only count while on; the previous result tracks regardless
  always_comb begin
    res_now  = {sync_b_q[SYNC_STAGES-1], sync_a_q[SYNC_STAGES-1]};
    prev_d   = res_now;
    rise_evt = res_now & ~prev_q & on_q;
    fall_evt = ~res_now & prev_q & on_q;
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      prev_q <= 2'b00;
    end else begin
      prev_q <= prev_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register bus decode

  always_comb begin
    sel      = page_hit(SFR_REQ_I.page);
    hit_ctrl = SFR_REQ_I.addr == DCC_ADDR_CTRL;
    hit_mode = SFR_REQ_I.addr == DCC_ADDR_MODE;
    // Per-comparator write strobes
    wr_ctrl  = {2{SFR_REQ_I.wr & hit_ctrl}} & sel;
    wr_mode  = {2{SFR_REQ_I.wr & hit_mode}} & sel;
  end

  //////////////////////////////////////////////////////////////////////////
  // Control registers, same logic for both comparators

  // Software write first, then hardware edges on top
  always_comb begin
    on_d        = on_q;
    rise_flag_d = rise_flag_q;
    fall_flag_d = fall_flag_q;
    pos_hyst_d  = pos_hyst_q;
    neg_hyst_d  = neg_hyst_q;
    for (int i = 0; i < 2; i++) begin
      // Control write; the result bit is read-only
      if (wr_ctrl[i]) begin
        on_d[i]        = SFR_REQ_I.wdata[DCC_CTRL_ON_BIT];
        rise_flag_d[i] = SFR_REQ_I.wdata[DCC_CTRL_RISE_BIT];
        fall_flag_d[i] = SFR_REQ_I.wdata[DCC_CTRL_FALL_BIT];
        pos_hyst_d[i]  =
          SFR_REQ_I.wdata[DCC_CTRL_PHYST_LSB +: 2];
        neg_hyst_d[i]  =
          SFR_REQ_I.wdata[DCC_CTRL_NHYST_LSB +: 2];
      end
      // Hardware edge wins over a same-cycle clear
      if (rise_evt[i]) begin
        rise_flag_d[i] = 1'b1;
      end
      if (fall_evt[i]) begin
        fall_flag_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      on_q          <= {2{DCC_CTRL_RESET[DCC_CTRL_ON_BIT]}};
      rise_flag_q   <= {2{DCC_CTRL_RESET[DCC_CTRL_RISE_BIT]}};
      fall_flag_q   <= {2{DCC_CTRL_RESET[DCC_CTRL_FALL_BIT]}};
      pos_hyst_q[0] <= DCC_CTRL_RESET[DCC_CTRL_PHYST_LSB +: 2];
      pos_hyst_q[1] <= DCC_CTRL_RESET[DCC_CTRL_PHYST_LSB +: 2];
      neg_hyst_q[0] <= DCC_CTRL_RESET[DCC_CTRL_NHYST_LSB +: 2];
      neg_hyst_q[1] <= DCC_CTRL_RESET[DCC_CTRL_NHYST_LSB +: 2];
    end else begin
      on_q        <= on_d;
      rise_flag_q <= rise_flag_d;
      fall_flag_q <= fall_flag_d;
      pos_hyst_q  <= pos_hyst_d;
      neg_hyst_q  <= neg_hyst_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode registers, same logic for both comparators

  // Unused mode bits are never stored
  always_comb begin
    rise_irq_on_d = rise_irq_on_q;
    fall_irq_on_d = fall_irq_on_q;
    speed_sel_d   = speed_sel_q;
    for (int i = 0; i < 2; i++) begin
      if (wr_mode[i]) begin
        rise_irq_on_d[i] = SFR_REQ_I.wdata[DCC_MODE_RISE_ON_BIT];
        fall_irq_on_d[i] = SFR_REQ_I.wdata[DCC_MODE_FALL_ON_BIT];
        speed_sel_d[i]   =
          SFR_REQ_I.wdata[DCC_MODE_SPEED_LSB +: 2];
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rise_irq_on_q  <= {2{DCC_MODE_RESET[DCC_MODE_RISE_ON_BIT]}};
      fall_irq_on_q  <= {2{DCC_MODE_RESET[DCC_MODE_FALL_ON_BIT]}};
      speed_sel_q[0] <= DCC_MODE_RESET[DCC_MODE_SPEED_LSB +: 2];
      speed_sel_q[1] <= DCC_MODE_RESET[DCC_MODE_SPEED_LSB +: 2];
    end else begin
      rise_irq_on_q <= rise_irq_on_d;
      fall_irq_on_q <= fall_irq_on_d;
      speed_sel_q   <= speed_sel_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read path

  // Read mux; data holds between reads, unmapped reads give zero
  always_comb begin
    rdata_d = rdata_q;
    if (SFR_REQ_I.rd) begin
      rdata_d = 8'h00;
      for (int i = 0; i < 2; i++) begin
        if (sel[i] && hit_ctrl) begin
          // Result reads live, low while off
          rdata_d = ctrl_image(on_q[i], res_now[i] & on_q[i],
                               rise_flag_q[i], fall_flag_q[i],
                               pos_hyst_q[i], neg_hyst_q[i]);
        end
        if (sel[i] && hit_mode) begin
          rdata_d = mode_image(rise_irq_on_q[i], fall_irq_on_q[i],
                               speed_sel_q[i]);
        end
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin and interrupt outputs

  // Pin follows the result while on; interrupt needs flag and enable
  always_comb begin
    pin_d = res_now & on_q;
    irq_d = on_q & ((rise_flag_q & rise_irq_on_q) |
                    (fall_flag_q & fall_irq_on_q));
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pin_q <= 2'b00;
      irq_q <= 2'b00;
    end else begin
      pin_q <= pin_d;
      irq_q <= irq_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reset request

  // Only comparator A may ask for a reset, on a low result
  always_comb begin
    rst_req_d = CMP_A_RST_SEL_I & on_q[0] & ~res_now[0];
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_req_q <= 1'b0;
    end else begin
      rst_req_q <= rst_req_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Core settings go straight from register flops

  // Comparator A settings
  always_comb begin
    CMP_A_CFG_O.on        = on_q[0];
    CMP_A_CFG_O.speed_sel = speed_sel_q[0];
    CMP_A_CFG_O.pos_hyst  = pos_hyst_q[0];
    CMP_A_CFG_O.neg_hyst  = neg_hyst_q[0];
  end

  // Comparator B mirrors A
  always_comb begin
    CMP_B_CFG_O.on        = on_q[1];
    CMP_B_CFG_O.speed_sel = speed_sel_q[1];
    CMP_B_CFG_O.pos_hyst  = pos_hyst_q[1];
    CMP_B_CFG_O.neg_hyst  = neg_hyst_q[1];
  end

  assign SFR_RDATA_O     = rdata_q;
  assign CMP_A_PIN_O     = pin_q[0];
  assign CMP_B_PIN_O     = pin_q[1];
  assign CMP_A_IRQ_O     = irq_q[0];
  assign CMP_B_IRQ_O     = irq_q[1];
  assign CMP_A_RST_REQ_O = rst_req_q;

endmodule

// ### shared/dcc_pkg.sv
package dcc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] DCC_PAGE_A     = 8'h01;
  localparam logic [7:0] DCC_PAGE_B     = 8'h02;
  localparam logic [7:0] DCC_ADDR_CTRL  = 8'h88;
  localparam logic [7:0] DCC_ADDR_MODE  = 8'h89;
  localparam logic [7:0] DCC_CTRL_RESET = 8'h00;
  localparam logic [7:0] DCC_MODE_RESET = 8'h02;

  //////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int DCC_CTRL_ON_BIT    = 7;
  localparam int DCC_CTRL_RES_BIT   = 6;
  localparam int DCC_CTRL_RISE_BIT  = 5;
  localparam int DCC_CTRL_FALL_BIT  = 4;
  localparam int DCC_CTRL_PHYST_LSB = 2;
  localparam int DCC_CTRL_NHYST_LSB = 0;

  //////////////////////////////////////////////////////////////////////////
  // Mode register fields
  localparam int DCC_MODE_RISE_ON_BIT = 5;
  localparam int DCC_MODE_FALL_ON_BIT = 4;
  localparam int DCC_MODE_SPEED_LSB   = 0;

  // Synchroniser depth
  localparam int DCC_SYNC_STAGES = 2;

  //////////////////////////////////////////////////////////////////////////
  // Settings presented to one analog comparator core
  typedef struct packed {
    logic       on;
    logic [1:0] speed_sel;
    logic [1:0] pos_hyst;
    logic [1:0] neg_hyst;
  } dcc_core_cfg_type;

  // Register-bus request
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } dcc_sfr_req_type;

endpackage

// ### testbench/dcc_monitor.sv
`timescale 1ns/10ps
module dcc_monitor
  import dcc_pkg::*;
(
  input wire logic             REF_CLK_I,
  input wire logic             RSTN_I,
  input wire dcc_sfr_req_type  SFR_REQ_I,
  input wire logic [7:0]       SFR_RDATA_O,
  input wire logic             CMP_A_RAW_I,
  input wire logic             CMP_B_RAW_I,
  input wire logic             CMP_A_RST_SEL_I,
  input wire dcc_core_cfg_type CMP_A_CFG_O,
  input wire dcc_core_cfg_type CMP_B_CFG_O,
  input wire logic             CMP_A_PIN_O,
  input wire logic             CMP_B_PIN_O,
  input wire logic             CMP_A_IRQ_O,
  input wire logic             CMP_B_IRQ_O,
  input wire logic             CMP_A_RST_REQ_O
);
  ////////////////////////////////////////////////////////////////////////
  // Decoded bus requests and last write data
  wire        wr_a = SFR_REQ_I.wr && SFR_REQ_I.page == DCC_PAGE_A;
  wire        wr_b = SFR_REQ_I.wr && SFR_REQ_I.page == DCC_PAGE_B;
  wire        rd_a = SFR_REQ_I.rd && SFR_REQ_I.page == DCC_PAGE_A;
  wire        is_ctl   = SFR_REQ_I.addr == DCC_ADDR_CTRL;
  wire        is_mode  = SFR_REQ_I.addr == DCC_ADDR_MODE;
  wire        on_raw_a = CMP_A_CFG_O.on && CMP_A_RAW_I;
  logic [7:0] wd_q;
  always_ff @(posedge REF_CLK_I) begin
    wd_q <= SFR_REQ_I.wdata;
  end
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  ////////////////////////////////////////////////////////////////////////
  AST_CTRL_WRITE: assert property (wr_a && is_ctl
    |=> CMP_A_CFG_O.on == wd_q[7] && CMP_A_CFG_O.pos_hyst == wd_q[3:2]
    && CMP_A_CFG_O.neg_hyst == wd_q[1:0]) else $error("ctrl A write lost");
  AST_B_WRITE: assert property (wr_b && is_ctl
    |=> CMP_B_CFG_O.on == wd_q[7] && CMP_B_CFG_O.pos_hyst == wd_q[3:2])
    else $error("ctrl B write lost");
  AST_SPEED_WRITE: assert property (wr_a && is_mode
    |=> CMP_A_CFG_O.speed_sel == wd_q[1:0]) else $error("speed A lost");
  AST_MODE_ZERO: assert property (rd_a && is_mode
    |=> SFR_RDATA_O[7:6] == 2'h0 && SFR_RDATA_O[3:2] == 2'h0)
    else $error("unused mode bits set");
  AST_CFG_HOLD: assert property (!SFR_REQ_I.wr
    |=> $stable(CMP_A_CFG_O)) else $error("cfg A changed without write");
  AST_PIN_OFF: assert property (!CMP_A_CFG_O.on [*2] |-> !CMP_A_PIN_O)
    else $error("pin A high while off");
  AST_IRQ_OFF: assert property (!CMP_A_CFG_O.on [*2] |-> !CMP_A_IRQ_O)
    else $error("irq A while off");
  AST_B_IRQ_OFF: assert property (!CMP_B_CFG_O.on [*2]
    |-> !CMP_B_IRQ_O) else $error("irq B while off");
  AST_PIN_HIGH: assert property (on_raw_a [*6]
    |-> CMP_A_PIN_O) else $error("pin A not following result");
  AST_B_PIN_LOW: assert property ((!CMP_B_RAW_I) [*6]
    |-> !CMP_B_PIN_O) else $error("pin B high with result low");
  AST_IRQ_HOLD: assert property ($fell(CMP_A_IRQ_O)
    |-> $past(SFR_REQ_I.wr) || $past(SFR_REQ_I.wr, 2))
    else $error("irq A dropped without write");
  AST_RST_NOSEL: assert property (!CMP_A_RST_SEL_I [*2]
    |-> !CMP_A_RST_REQ_O) else $error("reset request without select");
  // Main scenarios reached
  cover property (CMP_A_IRQ_O);
  cover property (CMP_B_IRQ_O);
  cover property (CMP_A_RST_REQ_O);
endmodule

bind dcc_top dcc_monitor u_mon (.REF_CLK_I, .RSTN_I, .SFR_REQ_I,
  .SFR_RDATA_O, .CMP_A_RAW_I, .CMP_B_RAW_I, .CMP_A_RST_SEL_I,
  .CMP_A_CFG_O, .CMP_B_CFG_O, .CMP_A_PIN_O, .CMP_B_PIN_O,
  .CMP_A_IRQ_O, .CMP_B_IRQ_O, .CMP_A_RST_REQ_O);

// ### testbench/dual_comparator_control_bench.sv
`timescale 1ns/10ps
module dual_comparator_control_bench;
  import dcc_pkg::*;
  logic             clk, rstn, sel, pin_a, pin_b, irq_a, irq_b, rreq;
  logic             raw [2];
  dcc_sfr_req_type  req;
  logic [7:0]       rdata, ctl [2], md [2];
  dcc_core_cfg_type cfg_a, cfg_b;
  int               failures, samples_checked, cycles;

  dcc_top DUT (.REF_CLK_I(clk), .RSTN_I(rstn), .SFR_REQ_I(req),
    .SFR_RDATA_O(rdata), .CMP_A_RAW_I(raw[0]), .CMP_B_RAW_I(raw[1]),
    .CMP_A_RST_SEL_I(sel), .CMP_A_CFG_O(cfg_a), .CMP_B_CFG_O(cfg_b),
    .CMP_A_PIN_O(pin_a), .CMP_B_PIN_O(pin_b), .CMP_A_IRQ_O(irq_a),
    .CMP_B_IRQ_O(irq_b), .CMP_A_RST_REQ_O(rreq));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare, bus cycles and model
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input int p, input logic [7:0] a, input logic [7:0] d);
    req.page = 8'(p + 1);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge clk);
    req.wr = 1'b0;
    if (a == DCC_ADDR_CTRL) ctl[p] = d & 8'hBF;
    if (a == DCC_ADDR_MODE) md[p] = d & 8'h33;
    @(negedge clk);
  endtask
  task automatic rd(input int p, input logic [7:0] a, input logic [7:0] e);
    req.page = 8'(p + 1);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge clk);
    req.rd = 1'b0;
    chk("read data", e, rdata);
    @(negedge clk);
  endtask
  // Full observation of one comparator against the model
  task automatic look(input int p);
    logic [7:0] c;
    logic       on, irq;
    c = ctl[p];
    on = c[7];
    irq = on & ((c[5] & md[p][5]) | (c[4] & md[p][4]));
    rd(p, DCC_ADDR_CTRL, {on, on & raw[p], c[5:0]});
    rd(p, DCC_ADDR_MODE, md[p]);
    chk("cfg", {1'b0, on, md[p][1:0], c[3:0]},
        {1'b0, p ? cfg_b : cfg_a});
    chk("pin", {7'h00, on & raw[p]}, {7'h00, p ? pin_b : pin_a});
    chk("irq", {7'h00, irq}, {7'h00, p ? irq_b : irq_a});
    if (p == 0) chk("rst req", {7'h00, sel & on & ~raw[0]},
                    {7'h00, rreq});
  endtask
  // Move a raw result and let the synchroniser settle
  task automatic edge_to(input int p, input logic b);
    if (ctl[p][7] && raw[p] !== b) ctl[p][b ? 5 : 4] = 1'b1;
    raw[p] = b;
    repeat (6) @(negedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn = 1'b0;
    req = '0;
    raw = '{1'b0, 1'b0};
    sel = 1'b0;
    ctl = '{DCC_CTRL_RESET, DCC_CTRL_RESET};
    md = '{DCC_MODE_RESET, DCC_MODE_RESET};
    void'($urandom(81));
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    for (int p = 0; p < 2; p++) look(p);
    rd(2, DCC_ADDR_CTRL, 8'h00);
    rd(0, 8'h8A, 8'h00);
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      repeat (6) begin
        wr(p, DCC_ADDR_CTRL, 8'($urandom) & 8'h8F);
        wr(p, DCC_ADDR_MODE, 8'($urandom) & 8'hCF);
        look(p);
      end
      for (int s = 0; s < 4; s++) begin
        wr(p, DCC_ADDR_MODE, 8'(s));
        look(p);
      end
    end
    $display("test registers done");
    sel = 1'b1;
    for (int p = 0; p < 2; p++) begin
      wr(p, DCC_ADDR_CTRL, 8'h80);
      wr(p, DCC_ADDR_CTRL, 8'h80);
      wr(p, DCC_ADDR_MODE, 8'h20);
      edge_to(p, 1'b1);
      look(p);
      wr(p, DCC_ADDR_CTRL, 8'h80);
      look(p);
      edge_to(p, 1'b0);
      look(p);
      repeat (20) @(negedge clk);
      look(p);
      wr(p, DCC_ADDR_MODE, 8'h30);
      look(p);
      wr(p, DCC_ADDR_CTRL, 8'h00);
      look(p);
      edge_to(p, 1'b1);
      look(p);
      edge_to(p, 1'b0);
      look(p);
    end
    $display("test edges done");
    complete_run();
  end
endmodule
